// File: rtl/sqr_params.svh
`ifndef SQR_PARAMS_SVH
`define SQR_PARAMS_SVH
// apb byte offsets
`define SQR_OFF_CTRL 12'h000
`define SQR_OFF_ERR 12'h004
`define SQR_OFF_QRY 12'h008
// control fields: terminator, eoi mode, trigger source, format, srq enable
`define SQR_CTRL_TERM 0
`define SQR_CTRL_EOI 2
`define SQR_CTRL_TRIG 4
`define SQR_CTRL_FMT 8
`define SQR_CTRL_SRQ 12
`define SQR_CTRL_MASK 32'h0000_1FFF
`define SQR_CTRL_RST 32'h0000_0070
// error word bit positions
`define SQR_ERR_CMD 0
`define SQR_ERR_OPT 1
`define SQR_ERR_REM 2
`define SQR_ERR_TST 3
`define SQR_ERR_OVR 4
`define SQR_ERR_EARLY 5
`define SQR_ERR_LOOP 6
`define SQR_ERR_INIT 7
`define SQR_ERR_SETUP 8
`define SQR_ERR_W 9
// query argument limits
`define SQR_MAX_SETUP 7'h64
`define SQR_MAX_UNIT 7'h04
// ascii characters
`define SQR_ASC_0 8'h30
`define SQR_ASC_1 8'h31
`define SQR_ASC_CR 8'h0D
`define SQR_ASC_LF 8'h0A
`define SQR_ASC_COMMA 8'h2C
`define SQR_ASC_SP 8'h20
`endif

// File: rtl/sqr_pkg.sv
package sqr_pkg;
    typedef enum logic [1:0] {
        SQR_IDLE,
        SQR_BODY,
        SQR_STREAM,
        SQR_TERM
    } sqr_state_type;
    typedef enum logic [3:0] {
        mode_word_query = 4'h0,
        error_word_query = 4'h1,
        setup_dump_query = 4'h2,
        step_pointer_query = 4'h3,
        slave_count_query = 4'h4,
        card_model_query = 4'h5,
        settle_time_query = 4'h6,
        port_input_query = 4'h7,
        check_pins_query = 4'h8,
        revision_item = 4'hE,
        no_item = 4'hF
    } sqr_query_type;
endpackage

// File: rtl/sqr_responder.sv
`timescale 1ns/10ps
`default_nettype none
`include "sqr_params.svh"

// What this block does
// R1: selector 0 sends the mode word
// R2: selector 1 sends error bits as ascii
// R3: error bits latch until the word is read
// R4: any error shows poll flag, optional srq
// R5: unknown letter or bad option set bits
// R6: execute while not remote sets error
// R7: rom or ram self-test fault sets bit
// R8: trigger before ready ignored, overrun set
// R9: trigger before settled processed, early set
// R10: chain fault sets loop error bit
// R11: card checksum fault at power-up flagged
// R12: bad stored setup flagged and cleared
// R13: selector 2 dumps setup in present format
// R14: selector 3 sends relay step pointer
// R15: selector 4 sends slave count
// R16: selector 5 sends card models, NONE empty
// R17: selector 6 sends longest settling milliseconds
// R18: selector 7 sends master digital inputs
// R19: selector 8 sends relay-test pins 0-15
// R20: each query answered by one talk only
// R21: item state taken at talk time
// R22: no query yet: revision, two spaces
// R23: selector and argument held until replaced
module sqr_responder #(
    parameter int SLOTS = 6,
    parameter logic [7:0] REV_LETTER = 8'h41, // arbitrary value
    parameter logic [15:0] REV_NUM = 16'h000A // arbitrary value
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic query_valid_in,
    input wire logic [3:0] query_sel_in,
    input wire logic [6:0] query_arg_in,
    input wire logic talk_req_in,
    output logic [7:0] byte_out,
    output logic byte_valid_out,
    output logic byte_eoi_out,
    input wire logic byte_ready_in,
    output logic setup_req_out,
    output logic [6:0] setup_idx_out,
    input wire logic [7:0] setup_byte_in,
    input wire logic setup_valid_in,
    input wire logic setup_last_in,
    output logic setup_ready_out,
    input wire logic invalid_command_error_in,
    input wire logic invalid_option_error_in,
    input wire logic execute_in,
    input wire logic remote_in,
    input wire logic rom_fail_in,
    input wire logic ram_fail_in,
    input wire logic trigger_in,
    input wire logic ready_in,
    input wire logic settled_in,
    output logic trigger_accept_out,
    input wire logic loop_fault_in,
    input wire logic powerup_in,
    input wire logic card_cksum_fail_in,
    input wire logic setup_cksum_bad_in,
    input wire logic [6:0] setup_check_idx_in,
    output logic setup_clear_out,
    output logic [6:0] setup_clear_idx_out,
    input wire logic [7:0] step_ptr_in,
    input wire logic [2:0] slave_count_in,
    input wire logic [15:0] settle_ms_in,
    input wire logic [7:0] port_in,
    input wire logic [3:0] check_pins_in,
    input wire logic [SLOTS*16-1:0] card_model_in,
    output logic [2:0] card_unit_out,
    output logic poll_error_out,
    output logic srq_out
);
    import sqr_pkg::*;

    // *****************************************
    // helpers
    // *****************************************
    // decimal digit p of v as ascii
    function automatic logic [7:0] dec_char(input logic [15:0] v, input logic [2:0] p);
        logic [15:0] d;
        d = v;
        unique case (p)
            3'd0: d = v;
            3'd1: d = v / 16'd10;
            3'd2: d = v / 16'd100;
            3'd3: d = v / 16'd1000;
            default: d = v / 16'd10000;
        endcase
        return `SQR_ASC_0 + 8'(d % 16'd10);
    endfunction

    // one character of a card slot field: four bcd digits or NONE
    function automatic logic [7:0] card_char(input logic [15:0] m, input logic [2:0] k);
        logic [7:0] c;
        c = `SQR_ASC_COMMA;
        if (m == 16'h0000) begin
            unique case (k)
                3'd0: c = 8'h4E;
                3'd1: c = 8'h4F;
                3'd2: c = 8'h4E;
                3'd3: c = 8'h45;
                default: c = `SQR_ASC_COMMA;
            endcase
        end else if (k < 3'd4) begin
            c = `SQR_ASC_0 + {4'h0, 4'(m >> (5'd12 - {k[1:0], 2'b00}))};
        end
        return c;
    endfunction

    // *****************************************
    // register bus
    // *****************************************
    logic [31:0] ctrl_q;
    logic [`SQR_ERR_W-1:0] err_q;
    logic [3:0] sel_q;
    logic [6:0] arg_q;
    logic pending_q;
    logic ever_q;
    logic apb_hit;
    logic [1:0] term_sel;
    logic eoi_en;
    logic srq_en;

    assign apb_hit = (paddr_in == `SQR_OFF_CTRL) || (paddr_in == `SQR_OFF_ERR) || (paddr_in == `SQR_OFF_QRY);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !apb_hit;
    assign term_sel = ctrl_q[`SQR_CTRL_TERM +: 2];
    assign eoi_en = !ctrl_q[`SQR_CTRL_EOI];
    assign srq_en = ctrl_q[`SQR_CTRL_SRQ];

    // control word, written in the access phase
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= `SQR_CTRL_RST;
        end else if (psel_in && penable_in && pwrite_in && paddr_in == `SQR_OFF_CTRL) begin
            ctrl_q <= pwdata_in & `SQR_CTRL_MASK;
        end
    end

    // read data staged in setup; error view here does not clear the bits
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in) begin
            unique case (paddr_in)
                `SQR_OFF_CTRL: prdata_out <= ctrl_q;
                `SQR_OFF_ERR: prdata_out <= {23'h00_0000, err_q};
                `SQR_OFF_QRY: prdata_out <= {18'h0_0000, ever_q, pending_q, 1'b0, arg_q, sel_q};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // *****************************************
    // error word
    // *****************************************
    logic [`SQR_ERR_W-1:0] err_set;
    logic err_clr;
    logic bad_query;
    logic talk_start;
    sqr_state_type state_q;

    assign bad_query = query_valid_in && ((query_sel_in > 4'h8)
        || (query_sel_in == 4'h2 && query_arg_in > `SQR_MAX_SETUP)
        || (query_sel_in == 4'h5 && query_arg_in > `SQR_MAX_UNIT));
    assign talk_start = talk_req_in && state_q == SQR_IDLE;
    assign err_clr = talk_start && pending_q && sel_q == 4'h1; // R3

    // event sources of each error bit
    always_comb begin
        err_set = '0;
        err_set[`SQR_ERR_CMD] = invalid_command_error_in; // R5
        err_set[`SQR_ERR_OPT] = invalid_option_error_in || bad_query; // R5
        err_set[`SQR_ERR_REM] = execute_in && !remote_in; // R6
        err_set[`SQR_ERR_TST] = rom_fail_in || ram_fail_in; // R7
        err_set[`SQR_ERR_OVR] = trigger_in && !ready_in; // R8
        err_set[`SQR_ERR_EARLY] = trigger_in && ready_in && !settled_in; // R9
        err_set[`SQR_ERR_LOOP] = loop_fault_in; // R10
        err_set[`SQR_ERR_INIT] = powerup_in && card_cksum_fail_in; // R11
        err_set[`SQR_ERR_SETUP] = powerup_in && setup_cksum_bad_in; // R12
    end

    // sticky bits; a new event in the clearing cycle survives
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            err_q <= '0;
        end else begin
            err_q <= (err_q & {`SQR_ERR_W{!err_clr}}) | err_set; // R3
        end
    end

    // early triggers still go through, overruns do not
    assign trigger_accept_out = trigger_in && ready_in; // R8 R9
    assign poll_error_out = |err_q; // R4

    // service request on a fresh error when enabled
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            srq_out <= 1'b0;
        end else begin
            srq_out <= srq_en && |err_set; // R4
        end
    end

    // corrupted stored setup is wiped by the setup store
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            setup_clear_out <= 1'b0;
            setup_clear_idx_out <= 7'h00;
        end else begin
            setup_clear_out <= powerup_in && setup_cksum_bad_in; // R12
            setup_clear_idx_out <= setup_check_idx_in;
        end
    end

    // *****************************************
    // query capture
    // *****************************************
    // last good query is kept; a query landing with a talk wins
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sel_q <= 4'h0;
            arg_q <= 7'h00;
            pending_q <= 1'b0;
            ever_q <= 1'b0;
        end else if (query_valid_in && !bad_query) begin
            sel_q <= query_sel_in; // R23
            arg_q <= query_arg_in;
            pending_q <= 1'b1;
            ever_q <= 1'b1;
        end else if (talk_start) begin
            pending_q <= 1'b0; // R20
        end
    end

    assign card_unit_out = arg_q[2:0]; // R16

    // *****************************************
    // talker
    // *****************************************
    sqr_query_type item_q;
    logic [15:0] snap_q;
    logic [`SQR_ERR_W-1:0] err_snap_q;
    logic [6:0] ptr_q;
    logic [6:0] body_len;
    logic [7:0] ch;
    logic load_ok;
    logic take;
    logic term_last;
    logic body_last;

    // body length of each item in characters
    always_comb begin
        unique case (item_q)
            mode_word_query: body_len = 7'd8;
            error_word_query: body_len = 7'(`SQR_ERR_W);
            step_pointer_query: body_len = 7'd3;
            slave_count_query: body_len = 7'd1;
            card_model_query: body_len = 7'(SLOTS * 5 - 1);
            settle_time_query: body_len = 7'd5;
            port_input_query: body_len = 7'd3;
            check_pins_query: body_len = 7'd2;
            revision_item: body_len = 7'd5;
            default: body_len = 7'd0;
        endcase
    end

    // item, and the error word or numeric value, are frozen when addressed to talk
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            item_q <= no_item;
            snap_q <= 16'h0000;
            err_snap_q <= '0;
        end else if (talk_start) begin
            item_q <= pending_q ? sqr_query_type'(sel_q) : (ever_q ? no_item : revision_item); // R20 R22
            err_snap_q <= err_q; // R21
            unique case (sel_q)
                4'h3: snap_q <= {8'h00, step_ptr_in}; // R14
                4'h4: snap_q <= {13'h0000, slave_count_in}; // R15
                4'h6: snap_q <= settle_ms_in; // R17
                4'h7: snap_q <= {8'h00, port_in}; // R18
                4'h8: snap_q <= {12'h000, check_pins_in}; // R19
                default: snap_q <= 16'h0000;
            endcase
        end
    end

    // next character of the item or of the terminator
    always_comb begin
        ch = `SQR_ASC_SP;
        if (state_q == SQR_STREAM) begin
            ch = setup_byte_in; // R13
        end else if (state_q == SQR_TERM) begin
            unique case (term_sel)
                2'd0: ch = (ptr_q == 7'd0) ? `SQR_ASC_CR : `SQR_ASC_LF;
                2'd1: ch = (ptr_q == 7'd0) ? `SQR_ASC_LF : `SQR_ASC_CR;
                2'd2: ch = `SQR_ASC_CR;
                2'd3: ch = `SQR_ASC_LF;
            endcase
        end else begin
            unique case (item_q)
                mode_word_query: begin
                    unique case (ptr_q[2:0])
                        3'd0: ch = 8'h47;
                        3'd1: ch = `SQR_ASC_0 + {4'h0, ctrl_q[`SQR_CTRL_FMT +: 4]};
                        3'd2: ch = 8'h4B;
                        3'd3: ch = `SQR_ASC_0 + {6'h00, ctrl_q[`SQR_CTRL_EOI +: 2]};
                        3'd4: ch = 8'h54;
                        3'd5: ch = `SQR_ASC_0 + {4'h0, ctrl_q[`SQR_CTRL_TRIG +: 4]};
                        3'd6: ch = 8'h59;
                        3'd7: ch = `SQR_ASC_0 + {6'h00, term_sel};
                    endcase // R1
                end
                error_word_query: begin
                    ch = err_snap_q[4'(`SQR_ERR_W - 1) - ptr_q[3:0]] ? `SQR_ASC_1 : `SQR_ASC_0; // R2
                end
                card_model_query: begin
                    ch = card_char(card_model_in[(ptr_q / 7'd5) * 16 +: 16], 3'(ptr_q % 7'd5)); // R16
                end
                revision_item: begin
                    unique case (ptr_q[2:0])
                        3'd0: ch = REV_LETTER;
                        3'd1: ch = dec_char(REV_NUM, 3'd1);
                        3'd2: ch = dec_char(REV_NUM, 3'd0);
                        default: ch = `SQR_ASC_SP;
                    endcase // R22
                end
                default: ch = dec_char(snap_q, 3'(body_len - 7'd1 - ptr_q)); // R14 R15 R17 R18 R19
            endcase
        end
    end

    assign load_ok = !byte_valid_out || byte_ready_in;
    assign setup_ready_out = state_q == SQR_STREAM && load_ok;
    assign take = load_ok && (state_q == SQR_BODY || state_q == SQR_TERM
        || (state_q == SQR_STREAM && setup_valid_in));
    assign term_last = ptr_q == ((term_sel < 2'd2) ? 7'd1 : 7'd0);
    assign body_last = ptr_q == body_len - 7'd1;

    // sequencer: body, or streamed setup, then terminator
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= SQR_IDLE;
            ptr_q <= 7'h00;
        end else begin
            unique case (state_q)
                SQR_IDLE: begin
                    ptr_q <= 7'h00;
                    if (talk_start) begin
                        if (pending_q && sel_q == 4'h2) begin
                            state_q <= SQR_STREAM; // R13
                        end else if (pending_q || !ever_q) begin
                            state_q <= SQR_BODY;
                        end else begin
                            state_q <= SQR_TERM;
                        end
                    end
                end
                SQR_BODY: begin
                    if (take) begin
                        ptr_q <= body_last ? 7'h00 : ptr_q + 7'd1;
                        if (body_last) begin
                            state_q <= SQR_TERM;
                        end
                    end
                end
                SQR_STREAM: begin
                    if (take && setup_last_in) begin
                        state_q <= SQR_TERM;
                    end
                end
                SQR_TERM: begin
                    if (take) begin
                        ptr_q <= term_last ? 7'h00 : ptr_q + 7'd1;
                        if (term_last) begin
                            state_q <= SQR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // setup store request at the start of a dump
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            setup_req_out <= 1'b0;
            setup_idx_out <= 7'h00;
        end else begin
            setup_req_out <= talk_start && pending_q && sel_q == 4'h2; // R13
            if (talk_start) begin
                setup_idx_out <= arg_q;
            end
        end
    end

    // output byte register; eoi rides with the final terminator byte
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            byte_out <= 8'h00;
            byte_valid_out <= 1'b0;
            byte_eoi_out <= 1'b0;
        end else if (load_ok) begin
            byte_valid_out <= take;
            if (take) begin
                byte_out <= ch;
                byte_eoi_out <= eoi_en && state_q == SQR_TERM && term_last;
            end
        end
    end

    // *****************************************
    // checks
    // *****************************************
    localparam int REV_MAX = 3;

    property p_err_hold;
        @(posedge sys_clk_in) disable iff (reset_in)
        err_q[`SQR_ERR_CMD] && !err_clr |=> err_q[`SQR_ERR_CMD];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error bit dropped without read"); // R3

    property p_err_read_clear;
        @(posedge sys_clk_in) disable iff (reset_in)
        err_clr && !(|err_set) |=> err_q == '0 && err_snap_q == $past(err_q);
    endproperty
    a_err_read_clear: assert property (p_err_read_clear) else $error("error read did not clear"); // R3 R2

    property p_poll_flag;
        @(posedge sys_clk_in) disable iff (reset_in)
        invalid_command_error_in |=> poll_error_out;
    endproperty
    a_poll_flag: assert property (p_poll_flag) else $error("poll flag missing after error"); // R4 R5

    property p_srq;
        @(posedge sys_clk_in) disable iff (reset_in)
        execute_in && !remote_in && srq_en |=> srq_out && err_q[`SQR_ERR_REM];
    endproperty
    a_srq: assert property (p_srq) else $error("no service request on error"); // R4 R6

    property p_opt;
        @(posedge sys_clk_in) disable iff (reset_in)
        query_valid_in && query_sel_in > 4'h8 |=> err_q[`SQR_ERR_OPT] && $stable(sel_q);
    endproperty
    a_opt: assert property (p_opt) else $error("bad selector accepted"); // R5 R23

    property p_overrun;
        @(posedge sys_clk_in) disable iff (reset_in)
        trigger_in && !ready_in |-> !trigger_accept_out ##1 err_q[`SQR_ERR_OVR];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun trigger mishandled"); // R8

    property p_early;
        @(posedge sys_clk_in) disable iff (reset_in)
        trigger_in && ready_in && !settled_in |-> trigger_accept_out ##1 err_q[`SQR_ERR_EARLY];
    endproperty
    a_early: assert property (p_early) else $error("early trigger mishandled"); // R9

    property p_selftest;
        @(posedge sys_clk_in) disable iff (reset_in)
        rom_fail_in || ram_fail_in |=> err_q[`SQR_ERR_TST];
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test bit not set"); // R7

    property p_setup_clear;
        @(posedge sys_clk_in) disable iff (reset_in)
        powerup_in && setup_cksum_bad_in |=> setup_clear_out && err_q[`SQR_ERR_SETUP]
            && setup_clear_idx_out == $past(setup_check_idx_in);
    endproperty
    a_setup_clear: assert property (p_setup_clear) else $error("bad setup not cleared"); // R12

    property p_once;
        @(posedge sys_clk_in) disable iff (reset_in)
        talk_start && !query_valid_in |=> !pending_q;
    endproperty
    a_once: assert property (p_once) else $error("query answered twice"); // R20

    property p_revision;
        @(posedge sys_clk_in) disable iff (reset_in)
        talk_start && !ever_q && byte_ready_in |-> ##[1:REV_MAX] byte_valid_out && byte_out == REV_LETTER;
    endproperty
    a_revision: assert property (p_revision) else $error("revision not sent first"); // R22

    c_err_read: cover property (@(posedge sys_clk_in) disable iff (reset_in) err_clr && err_q != '0);
    c_revision: cover property (@(posedge sys_clk_in) disable iff (reset_in) talk_start && !ever_q);
    c_dump: cover property (@(posedge sys_clk_in) disable iff (reset_in) take && setup_last_in);
    c_early: cover property (@(posedge sys_clk_in) disable iff (reset_in) trigger_in && ready_in && !settled_in);
endmodule
`default_nettype wire

// File: verif/sqr_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// bus controller: queries, talk requests, byte sink
// ********
module sqr_ctrl_model (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [7:0] b_in,
    input wire logic bv_in,
    input wire logic eoi_in,
    output logic rdy_out,
    output logic qv_out,
    output logic [3:0] qs_out,
    output logic [6:0] qa_out,
    output logic talk_out
);
    logic [7:0] rx[$];
    logic done;
    initial {rdy_out, qv_out, talk_out, done, qs_out, qa_out} = '0;
    // byte taken on valid and ready; slow mode stalls every other cycle
    always @(posedge clk_in) begin
        rdy_out <= !slow_in || !rdy_out;
        if (bv_in && rdy_out) begin
            rx.push_back(b_in);
            done <= eoi_in;
        end
    end
    // lines go to garbage once the strobe drops, so a stale selector never helps
    task automatic query(input logic [3:0] s, input logic [6:0] a);
        @(posedge clk_in);
        {qv_out, qs_out, qa_out} <= {1'b1, s, a};
        @(posedge clk_in);
        {qv_out, qs_out, qa_out} <= {1'b0, ~s, ~a};
    endtask
    // talk straight after the query so the item is current
    task automatic talk();
        int n;
        rx.delete();
        done = 1'b0;
        @(posedge clk_in);
        talk_out <= 1'b1;
        @(posedge clk_in);
        talk_out <= 1'b0;
        for (n = 0; n < 99 && !done; n++) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: verif/sqr_responder_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ********
// stimulus, reference values and checks
// ********
module sqr_responder_tb;
    import sqr_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, rd = 0, rem = 0, pup = 1, slow = 0, sett = 0;
    logic pe, prdy, perr, qv, tk, brdy, bv, beoi, acc, poll;
    logic [3:0] qs, pins = 0;
    logic [3:0] qt[5] = '{3, 4, 6, 7, 8};
    logic [6:0] qa;
    logic [7:0] bo, step = 0, port = 0;
    logic [2:0] slaves = 1;
    logic [8:0] ev = 0, em = 0, x;
    logic [11:0] pa = 0;
    logic [15:0] settle = 0;
    logic [31:0] pwd = 0, prd, rv;
    int seed = 98281, err_total = 0, check_count = 0, cyc = 0;
    string s, tt[4] = '{"\015\012", "\012\015", "\015", "\012"};
    sqr_responder sqr_responder_inst (.sys_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .query_valid_in(qv), .query_sel_in(qs), .query_arg_in(qa), .talk_req_in(tk), .byte_out(bo),
        .byte_valid_out(bv), .byte_eoi_out(beoi), .byte_ready_in(brdy), .setup_req_out(), .setup_idx_out(),
        .setup_byte_in(8'h00), .setup_valid_in(1'b0), .setup_last_in(1'b0), .setup_ready_out(),
        .invalid_command_error_in(ev[0]), .invalid_option_error_in(ev[1]), .execute_in(ev[2]), .remote_in(rem),
        .rom_fail_in(ev[3] & !rd), .ram_fail_in(ev[3] & rd), .trigger_in(ev[4]), .ready_in(rd),
        .settled_in(sett), .trigger_accept_out(acc), .loop_fault_in(ev[6]), .powerup_in(pup),
        .card_cksum_fail_in(ev[7]), .setup_cksum_bad_in(ev[8]), .setup_check_idx_in(7'h05),
        .setup_clear_out(), .setup_clear_idx_out(), .step_ptr_in(step), .slave_count_in(slaves),
        .settle_ms_in(settle), .port_in(port), .check_pins_in(pins), .card_model_in({16'h1234, 80'h0}),
        .card_unit_out(),
        .poll_error_out(poll), .srq_out());
    sqr_ctrl_model ctl (.clk_in(clk), .slow_in(slow), .b_in(bo), .bv_in(bv), .eoi_in(beoi),
        .rdy_out(brdy), .qv_out(qv), .qs_out(qs), .qa_out(qa), .talk_out(tk));
    initial forever #20 clk = ~clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rx(input string x);
        bit bad;
        check_count++;
        bad = ctl.rx.size() != x.len();
        foreach (ctl.rx[i]) if (i >= x.len() || ctl.rx[i] !== x[i]) bad = 1;
        if (bad) begin
            err_total++;
            $display("[ERR] %0t bytes differ from %s", $time, x);
        end
    endtask
    // request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        {rv, pe} = {prd, perr};
        {psel, pen} <= 2'b00;
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ********
    // scenarios
    // ********
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        ctl.talk();
        chk_rx("A10  \015\012");
        for (int k = 0; k < 5; k++) begin
            rv = $random(seed);
            slow <= rv[12];
            ctl.query(qt[k], 7'h00);
            {port, settle, pins} <= rv[27:0];
            step <= rv[7:0] % 8'd101;
            slaves <= rv[9:8] + 3'd1;
            ctl.talk();
            case (k)
                0: s = $sformatf("%03d", step);
                1: s = $sformatf("%0d", slaves);
                2: s = $sformatf("%05d", settle);
                3: s = $sformatf("%03d", port);
                default: s = $sformatf("%02d", pins);
            endcase
            chk_rx({s, "\015\012"});
            ctl.talk();
            chk_rx("\015\012");
        end
        for (int y = 0; y < 4; y++) begin
            ctl.query(4'h4, 7'h00);
            apb(1'b1, 12'h000, 32'h0000_1070 | y);
            ctl.talk();
            chk_rx({$sformatf("%0d", slaves), tt[y]});
        end
        // control now 0x1073: srq on, terminator lf only
        ctl.query(4'h0, 7'h00);
        ctl.talk();
        chk_rx({"G0K0T7Y3", tt[3]});
        ctl.query(4'h5, 7'h02);
        ctl.talk();
        chk_rx({"NONE,NONE,NONE,NONE,NONE,1234", tt[3]});
        ctl.query(4'h9, 7'h00);
        em = 9'h002;
        for (int r = 0; r < 4; r++) begin
            rv = $random(seed);
            x = rv[8:0] & 9'h1DF;
            rd <= r[0];
            ev <= x;
            if (r[0] && x[4]) x = x ^ 9'h030;
            em = em | x;
            @(posedge clk);
            chk(acc, rv[4] & r[0]);
            ev <= 9'h000;
            apb(1'b0, 12'h004, 32'h0);
            chk(rv, em);
            chk(poll, em != 0);
            if (r[0]) begin
                ctl.query(4'h1, 7'h00);
                ctl.talk();
                chk_rx({$sformatf("%09b", em), tt[3]});
                em = 9'h000;
                chk(poll, 1'b0);
            end
        end
        apb(1'b0, 12'h00C, 32'h0);
        chk(pe, 1'b1);
        chk(rv, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
